/* File: common/dcc_cfg.svh */
// Purpose: Register map, field positions, reset values and select codes of the dual comparator control block.
// Assumes: Byte-wide special-function-register bus with 8-bit addresses.
// Notes:   Definitions only.
`ifndef DCC_CFG_SVH
`define DCC_CFG_SVH

// =====================================================================
// Register addresses
`define DCC_ADDR_C1_CTL   8'h9A
`define DCC_ADDR_C0_CTL   8'h9B
`define DCC_ADDR_C1_MODE  8'h9C
`define DCC_ADDR_C0_MODE  8'h9D
`define DCC_ADDR_C1_MUX   8'h9E
`define DCC_ADDR_C0_MUX   8'h9F

// =====================================================================
// Reset values
`define DCC_RST_CTL       8'h00
`define DCC_RST_MODE      8'h82
`define DCC_RST_MUX       8'hFF

// =====================================================================
// Control register fields
`define DCC_CTL_ON        7
`define DCC_CTL_RESULT    6
`define DCC_CTL_RISE      5
`define DCC_CTL_FALL      4
`define DCC_CTL_PHYS_HI   3
`define DCC_CTL_PHYS_LO   2
`define DCC_CTL_NHYS_HI   1
`define DCC_CTL_NHYS_LO   0

// =====================================================================
// Mode register fields
`define DCC_MODE_RSVD     7
`define DCC_MODE_RIE      5
`define DCC_MODE_FIE      4
`define DCC_MODE_SPD_HI   1
`define DCC_MODE_SPD_LO   0

// =====================================================================
// Input select fields and internal source codes
`define DCC_MUX_N_HI      7
`define DCC_MUX_N_LO      4
`define DCC_MUX_P_HI      3
`define DCC_MUX_P_LO      0
`define DCC_SRC_CAP_REF   4'hC
`define DCC_SRC_HALF_BATT 4'hD
`define DCC_SRC_N_DIGITAL 4'hE
`define DCC_SRC_N_GROUND  4'hF
`define DCC_SRC_P_BATT    4'hE
`define DCC_SRC_P_TOP     4'hF

`endif

/* File: common/dcc_pkg.sv */
// Purpose: Types shared by the dual comparator control block.
// Assumes: Nothing beyond the config header.
// Notes:   Source kinds tell the analog switches which internal node is chosen.
package dcc_pkg;

  // =====================================================================
  // Decoded input source kinds
  typedef enum logic [2:0] {
    dcc_plus_pin,
    dcc_plus_cap_ref,
    dcc_plus_half_batt,
    dcc_plus_batt,
    dcc_plus_converter
  } dcc_plus_kind_t;

  typedef enum logic [2:0] {
    dcc_minus_pin,
    dcc_minus_cap_ref,
    dcc_minus_half_batt,
    dcc_minus_digital,
    dcc_minus_ground
  } dcc_minus_kind_t;

endpackage : dcc_pkg

/* File: common/dcc_chan_if.sv */
// Purpose: Carries one comparator's control and status between the register bank and its channel logic.
// Assumes: Single clock domain.
// Notes:   The bank drives the control side, the channel drives the status side.
`timescale 1ns/1ps

interface dcc_chan_if;
  logic on;
  logic ctl_wr;
  logic wr_rise;
  logic wr_fall;
  logic rise_en;
  logic fall_en;
  logic raw_sync;
  logic result;
  logic rise_flag;
  logic fall_flag;
  logic irq;

  modport bank (output on, ctl_wr, wr_rise, wr_fall, rise_en, fall_en, raw_sync,
                input  result, rise_flag, fall_flag, irq);
  modport core (input  on, ctl_wr, wr_rise, wr_fall, rise_en, fall_en, raw_sync,
                output result, rise_flag, fall_flag, irq);
endinterface : dcc_chan_if

/* File: verilog/dcc_sync.sv */
// Purpose: Multi-stage synchroniser for the comparator outputs.
// Assumes: Inputs may change at any time relative to ref_clk.
// Notes:   Only the last stage is visible outside.
`timescale 1ns/1ps

module dcc_sync #(
  parameter int WIDTH  = 2,
  parameter int STAGES = 2
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_r [STAGES];

  if (STAGES < 2) begin : g_chk
    $error("dcc_sync needs at least two stages");
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int s = 0; s < STAGES; s++) stage_r[s] <= '0;
    end else begin
      stage_r[0] <= async_in;
      for (int s = 1; s < STAGES; s++) stage_r[s] <= stage_r[s-1];
    end
  end

  assign sync_out = stage_r[STAGES-1];
endmodule : dcc_sync

/* File: verilog/dcc_chan.sv */
// Purpose: One comparator's gated result, edge flags and interrupt request.
// Assumes: raw_sync is already synchronised to ref_clk.
// Notes:   Flags are written from the control register write; a hardware set wins.
`timescale 1ns/1ps

module dcc_chan (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Bank side
  dcc_chan_if.core bus
);
  logic result_r, result_nxt;
  logic rise_r, rise_nxt;
  logic fall_r, fall_nxt;
  logic irq_r, irq_nxt;
  logic rise_ev, fall_ev;

  // =====================================================================
  // Gating and edge detection
  assign result_nxt = bus.on & bus.raw_sync;                       // RL19
  assign rise_ev    = bus.on & result_nxt & ~result_r;             // RL22
  assign fall_ev    = bus.on & ~result_nxt & result_r;             // RL1
  assign rise_nxt   = rise_ev | (bus.ctl_wr ? bus.wr_rise : rise_r); // RL4
  assign fall_nxt   = fall_ev | (bus.ctl_wr ? bus.wr_fall : fall_r); // RL5
  assign irq_nxt    = bus.on & ((rise_r & bus.rise_en) | (fall_r & bus.fall_en)); // RL21

  // =====================================================================
  // State
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      result_r <= 1'b0;
      rise_r   <= 1'b0;
      fall_r   <= 1'b0;
      irq_r    <= 1'b0;
    end else begin
      result_r <= result_nxt;   // RL3
      rise_r   <= rise_nxt;     // RL18
      fall_r   <= fall_nxt;     // RL18
      irq_r    <= irq_nxt;      // RL9 RL10
    end
  end

  assign bus.result    = result_r;
  assign bus.rise_flag = rise_r;
  assign bus.fall_flag = fall_r;
  assign bus.irq       = irq_r;
endmodule : dcc_chan

/* File: verilog/dcc_top.sv */
// Purpose: Register bank and status logic for two voltage comparators on the SFR bus.
// Assumes: Single-cycle SFR read and write strobes; raw comparator outputs are asynchronous.
// Notes:   Read data appears one cycle after the read strobe.
`timescale 1ns/1ps
`include "dcc_cfg.svh"

// Summary of operation
// (RL1) A comparator does nothing until its enable bit is written to 1.
// (RL2) Enable bit 0 powers the analog core down.
// (RL3) Control bit 6 reads the synchronised result, 1 when plus exceeds minus.
// (RL4) Control bit 5 latches rising edges until software writes 0.
// (RL5) Control bit 4 latches falling edges until software writes 0.
// (RL6) Control bits 3:2 drive positive hysteresis, 00 off.
// (RL7) Control bits 1:0 drive negative hysteresis, same encoding.
// (RL8) Mode bits 1:0 pick one of four speed and power settings.
// (RL9) Mode bit 5 lets the rising flag request an interrupt.
// (RL10) Mode bit 4 lets the falling flag request an interrupt.
// (RL11) Mode bit 7 resets to 1 and always reads 1.
// (RL12) Mode bits 6 and 3:2 read zero and ignore writes.
// (RL13) Select bits 7:4 drive the minus switches, codes C to F internal.
// (RL14) Select bits 3:0 drive the plus switches, codes C to F internal.
// (RL15) Plus code F means converter supply on comparator 1, battery on 0.
// (RL16) Software should clear both flags shortly after enabling or retuning.
// (RL17) Comparator 0 result feeds the capture timer.
// (RL18) Edge flags set regardless of interrupt enables.
// (RL19) A disabled comparator's result is forced to 0.
// (RL20) The raw output is synchronised to the system clock before use.
// (RL21) An interrupt is requested only by a set flag with its enable set.
// (RL22) Edges compare current and previous samples; hardware set beats software clear.
module dcc_top
  import dcc_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  // Clock and reset
  input  wire logic      ref_clk,
  input  wire logic      rst,
  // SFR bus
  input  wire logic [7:0] sfr_addr,
  input  wire logic      sfr_wr_en,
  input  wire logic      sfr_rd_en,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  output logic           sfr_hit,
  // Raw comparator outputs
  input  wire logic      comp0_raw_out,
  input  wire logic      comp1_raw_out,
  // Comparator 0 analog controls
  output logic           comp0_on,
  output logic      [1:0] comp0_pos_hyst,
  output logic      [1:0] comp0_neg_hyst,
  output logic      [1:0] comp0_speed_sel,
  output logic      [3:0] comp0_plus_source,
  output logic      [3:0] comp0_minus_source,
  output dcc_plus_kind_t  comp0_plus_kind,
  output dcc_minus_kind_t comp0_minus_kind,
  // Comparator 1 analog controls
  output logic           comp1_on,
  output logic      [1:0] comp1_pos_hyst,
  output logic      [1:0] comp1_neg_hyst,
  output logic      [1:0] comp1_speed_sel,
  output logic      [3:0] comp1_plus_source,
  output logic      [3:0] comp1_minus_source,
  output dcc_plus_kind_t  comp1_plus_kind,
  output dcc_minus_kind_t comp1_minus_kind,
  // Results and interrupt requests
  output logic           comp0_result,
  output logic           comp1_result,
  output logic           comp0_irq,
  output logic           comp1_irq,
  output logic           capture_timer_trigger
);
  localparam int NCMP = 2;

  localparam logic [7:0] CTL_ADDR  [NCMP] = '{`DCC_ADDR_C0_CTL,  `DCC_ADDR_C1_CTL};
  localparam logic [7:0] MODE_ADDR [NCMP] = '{`DCC_ADDR_C0_MODE, `DCC_ADDR_C1_MODE};
  localparam logic [7:0] MUX_ADDR  [NCMP] = '{`DCC_ADDR_C0_MUX,  `DCC_ADDR_C1_MUX};
  localparam logic [7:0] CTL_RST   = `DCC_RST_CTL;
  localparam logic [7:0] MODE_RST  = `DCC_RST_MODE;
  localparam logic [7:0] MUX_RST   = `DCC_RST_MUX;

  if (SYNC_STAGES < 2) begin : g_chk
    $error("dcc_top needs SYNC_STAGES of at least two");
  end

  // =====================================================================
  // Per-comparator register storage
  logic            on_r      [NCMP];
  logic [1:0]      phys_r    [NCMP];
  logic [1:0]      nhys_r    [NCMP];
  logic            rie_r     [NCMP];
  logic            fie_r     [NCMP];
  logic [1:0]      spd_r     [NCMP];
  logic [3:0]      nsel_r    [NCMP];
  logic [3:0]      psel_r    [NCMP];
  dcc_plus_kind_t  pkind_r   [NCMP];
  dcc_minus_kind_t nkind_r   [NCMP];
  dcc_plus_kind_t  pkind_nxt [NCMP];
  dcc_minus_kind_t nkind_nxt [NCMP];

  // =====================================================================
  // Per-comparator decode and status wires
  logic            hit_ctl   [NCMP];
  logic            hit_mode  [NCMP];
  logic            hit_mux   [NCMP];
  logic            wr_ctl    [NCMP];
  logic            wr_mode   [NCMP];
  logic            wr_mux    [NCMP];
  logic [7:0]      ctl_val   [NCMP];
  logic [7:0]      mode_val  [NCMP];
  logic [7:0]      mux_val   [NCMP];
  logic [7:0]      chan_rd   [NCMP];
  logic            chan_hit  [NCMP];
  logic            res_w     [NCMP];
  logic            irq_w     [NCMP];

  // =====================================================================
  // Synchronisation of the raw outputs
  logic [NCMP-1:0] raw_async;
  logic [NCMP-1:0] raw_sync;

  assign raw_async = {comp1_raw_out, comp0_raw_out};

  dcc_sync #(
    .WIDTH  (NCMP),
    .STAGES (SYNC_STAGES)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (raw_async),
    .sync_out (raw_sync)    // RL20
  );

  // =====================================================================
  // Per-comparator logic
  for (genvar i = 0; i < NCMP; i++) begin : g_cmp
    dcc_chan_if u_if ();

    assign hit_ctl[i]  = (sfr_addr == CTL_ADDR[i]);
    assign hit_mode[i] = (sfr_addr == MODE_ADDR[i]);
    assign hit_mux[i]  = (sfr_addr == MUX_ADDR[i]);
    assign wr_ctl[i]   = sfr_wr_en & hit_ctl[i];
    assign wr_mode[i]  = sfr_wr_en & hit_mode[i];
    assign wr_mux[i]   = sfr_wr_en & hit_mux[i];

    // Channel connections.
    assign u_if.on       = on_r[i];
    assign u_if.ctl_wr   = wr_ctl[i];
    assign u_if.wr_rise  = sfr_wdata[`DCC_CTL_RISE];
    assign u_if.wr_fall  = sfr_wdata[`DCC_CTL_FALL];
    assign u_if.rise_en  = rie_r[i];
    assign u_if.fall_en  = fie_r[i];
    assign u_if.raw_sync = raw_sync[i];
    assign res_w[i]      = u_if.result;
    assign irq_w[i]      = u_if.irq;

    dcc_chan u_chan (
      .ref_clk (ref_clk),
      .rst     (rst),
      .bus     (u_if.core)
    );

    // Read views of the three registers.
    assign ctl_val[i] = {on_r[i], u_if.result, u_if.rise_flag, u_if.fall_flag,
                         phys_r[i], nhys_r[i]};                      // RL3
    assign mode_val[i] = {1'b1, 1'b0, rie_r[i], fie_r[i], 2'b00, spd_r[i]}; // RL11 RL12
    assign mux_val[i]  = {nsel_r[i], psel_r[i]};
    assign chan_rd[i]  = ({8{hit_ctl[i]}} & ctl_val[i]) |
                         ({8{hit_mode[i]}} & mode_val[i]) |
                         ({8{hit_mux[i]}} & mux_val[i]);
    assign chan_hit[i] = hit_ctl[i] | hit_mode[i] | hit_mux[i];

    // Decode of the positive selection into an internal source kind.
    assign pkind_nxt[i] =
      (psel_r[i] == `DCC_SRC_CAP_REF)   ? dcc_plus_cap_ref :
      (psel_r[i] == `DCC_SRC_HALF_BATT) ? dcc_plus_half_batt :
      (psel_r[i] == `DCC_SRC_P_BATT)    ? dcc_plus_batt :
      (psel_r[i] == `DCC_SRC_P_TOP)     ? ((i == 1) ? dcc_plus_converter : dcc_plus_batt) : // RL15
                                          dcc_plus_pin;             // RL14

    // Decode of the negative selection into an internal source kind.
    assign nkind_nxt[i] =
      (nsel_r[i] == `DCC_SRC_CAP_REF)   ? dcc_minus_cap_ref :
      (nsel_r[i] == `DCC_SRC_HALF_BATT) ? dcc_minus_half_batt :
      (nsel_r[i] == `DCC_SRC_N_DIGITAL) ? dcc_minus_digital :
      (nsel_r[i] == `DCC_SRC_N_GROUND)  ? dcc_minus_ground :
                                          dcc_minus_pin;            // RL13

    // Control register.
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        on_r[i]   <= CTL_RST[`DCC_CTL_ON];
        phys_r[i] <= CTL_RST[`DCC_CTL_PHYS_HI:`DCC_CTL_PHYS_LO];
        nhys_r[i] <= CTL_RST[`DCC_CTL_NHYS_HI:`DCC_CTL_NHYS_LO];
      end else if (wr_ctl[i]) begin
        on_r[i]   <= sfr_wdata[`DCC_CTL_ON];                           // RL1 RL2
        phys_r[i] <= sfr_wdata[`DCC_CTL_PHYS_HI:`DCC_CTL_PHYS_LO];     // RL6
        nhys_r[i] <= sfr_wdata[`DCC_CTL_NHYS_HI:`DCC_CTL_NHYS_LO];     // RL7
      end
    end

    // Mode register; bits 7, 6 and 3:2 are not stored.
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        rie_r[i] <= MODE_RST[`DCC_MODE_RIE];
        fie_r[i] <= MODE_RST[`DCC_MODE_FIE];
        spd_r[i] <= MODE_RST[`DCC_MODE_SPD_HI:`DCC_MODE_SPD_LO];
      end else if (wr_mode[i]) begin
        rie_r[i] <= sfr_wdata[`DCC_MODE_RIE];                          // RL9
        fie_r[i] <= sfr_wdata[`DCC_MODE_FIE];                          // RL10
        spd_r[i] <= sfr_wdata[`DCC_MODE_SPD_HI:`DCC_MODE_SPD_LO];      // RL8
      end
    end

    // Input select register.
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        nsel_r[i] <= MUX_RST[`DCC_MUX_N_HI:`DCC_MUX_N_LO];
        psel_r[i] <= MUX_RST[`DCC_MUX_P_HI:`DCC_MUX_P_LO];
      end else if (wr_mux[i]) begin
        nsel_r[i] <= sfr_wdata[`DCC_MUX_N_HI:`DCC_MUX_N_LO];           // RL13
        psel_r[i] <= sfr_wdata[`DCC_MUX_P_HI:`DCC_MUX_P_LO];           // RL14
      end
    end

    // Registered source kinds for the switch drivers.
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        pkind_r[i] <= (i == 1) ? dcc_plus_converter : dcc_plus_batt;
        nkind_r[i] <= dcc_minus_ground;
      end else begin
        pkind_r[i] <= pkind_nxt[i];
        nkind_r[i] <= nkind_nxt[i];
      end
    end
  end

  // =====================================================================
  // SFR read port
  logic [7:0] rd_mux;
  logic       rd_mapped;
  logic [7:0] rdata_r;
  logic       hit_r;
  logic       cap_r;

  assign rd_mux    = chan_rd[0] | chan_rd[1];
  assign rd_mapped = chan_hit[0] | chan_hit[1];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_r <= 8'h00;
      hit_r   <= 1'b0;
    end else begin
      rdata_r <= sfr_rd_en ? rd_mux : 8'h00;
      hit_r   <= sfr_rd_en & rd_mapped;
    end
  end

  // The capture timer sees comparator 0's gated, synchronised result.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cap_r <= 1'b0;
    end else begin
      cap_r <= g_cmp[0].u_if.result;   // RL17
    end
  end

  // =====================================================================
  // Output assignments
  assign sfr_rdata             = rdata_r;
  assign sfr_hit               = hit_r;
  assign comp0_on              = on_r[0];    // RL2
  assign comp1_on              = on_r[1];    // RL2
  assign comp0_pos_hyst        = phys_r[0];
  assign comp1_pos_hyst        = phys_r[1];
  assign comp0_neg_hyst        = nhys_r[0];
  assign comp1_neg_hyst        = nhys_r[1];
  assign comp0_speed_sel       = spd_r[0];
  assign comp1_speed_sel       = spd_r[1];
  assign comp0_plus_source     = psel_r[0];
  assign comp1_plus_source     = psel_r[1];
  assign comp0_minus_source    = nsel_r[0];
  assign comp1_minus_source    = nsel_r[1];
  assign comp0_plus_kind       = pkind_r[0];
  assign comp1_plus_kind       = pkind_r[1];
  assign comp0_minus_kind      = nkind_r[0];
  assign comp1_minus_kind      = nkind_r[1];
  assign comp0_result          = res_w[0];
  assign comp1_result          = res_w[1];
  assign comp0_irq             = irq_w[0];
  assign comp1_irq             = irq_w[1];
  assign capture_timer_trigger = cap_r;

endmodule : dcc_top

/* File: testbench/dcc_comp_model.sv */
// Purpose: Behavioural analog core of one comparator.
// Assumes: plus_above is the bench's view of plus against minus.
// Notes:   Slower speed codes answer later; the output is asynchronous.
`timescale 1ns/1ps

module dcc_comp_model (
  // Controls
  input  wire logic       on,
  input  wire logic [1:0] speed_sel,
  // Analog side
  input  wire logic       plus_above,
  output logic            raw_out
);
  // ==========
  // Core
  initial raw_out = 1'b0;
  // A core that is powered down holds its output low.
  always @(on, plus_above, speed_sel) begin
    raw_out <= #(1 + 2 * speed_sel) (on & plus_above);
  end
endmodule : dcc_comp_model

/* File: testbench/dcc_checker.sv */
// Purpose: Concurrent checks on the ports of the comparator control block.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/1ps
`include "dcc_cfg.svh"

module dcc_checker
  import dcc_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  // Clock and reset
  input wire logic           ref_clk,
  input wire logic           rst,
  // SFR bus
  input wire logic [7:0]     sfr_addr,
  input wire logic           sfr_wr_en,
  input wire logic           sfr_rd_en,
  input wire logic [7:0]     sfr_wdata,
  input wire logic [7:0]     sfr_rdata,
  input wire logic           sfr_hit,
  // Comparator side
  input wire logic           comp0_raw_out,
  input wire logic           comp0_on,
  input wire logic [1:0]     comp0_pos_hyst,
  input wire logic [1:0]     comp0_neg_hyst,
  input wire logic [3:0]     comp0_minus_source,
  input wire logic [1:0]     comp1_speed_sel,
  input wire logic [3:0]     comp1_plus_source,
  input wire dcc_plus_kind_t comp1_plus_kind,
  input wire logic           comp0_result,
  input wire logic           comp0_irq,
  input wire logic           capture_timer_trigger
);
  // ==========
  // Helpers
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic mapped;
  assign mapped = sfr_addr >= `DCC_ADDR_C1_CTL && sfr_addr <= `DCC_ADDR_C0_MUX;
  sequence s_wr(logic [7:0] a); sfr_wr_en && sfr_addr == a; endsequence
  sequence s_rd(logic [7:0] a); sfr_rd_en && sfr_addr == a; endsequence

  // ==========
  // Assertions
  a_ctl_write: assert property (s_wr(`DCC_ADDR_C0_CTL) |=> comp0_on == $past(sfr_wdata[7])
    && comp0_pos_hyst == $past(sfr_wdata[3:2]) && comp0_neg_hyst == $past(sfr_wdata[1:0]))
    else $error("control write not applied");
  a_speed_write: assert property (s_wr(`DCC_ADDR_C1_MODE) |=> comp1_speed_sel == $past(sfr_wdata[1:0]))
    else $error("speed write not applied");
  a_minus_write: assert property (s_wr(`DCC_ADDR_C0_MUX) |=> comp0_minus_source == $past(sfr_wdata[7:4]))
    else $error("minus select not applied");
  a_conv_kind: assert property (s_wr(`DCC_ADDR_C1_MUX) ##0 sfr_wdata[3:0] == 4'hF
    |=> comp1_plus_source == 4'hF ##1 comp1_plus_kind == dcc_plus_converter) else $error("plus code F wrong");
  a_result_sync: assert property ($past(comp0_on) |-> comp0_result == $past(comp0_raw_out, SYNC_STAGES + 1))
    else $error("result not the synchronised raw output");
  a_off_quiet: assert property (!$past(comp0_on) |-> !comp0_result && !comp0_irq)
    else $error("disabled comparator active");
  a_trigger_copy: assert property (capture_timer_trigger == $past(comp0_result))
    else $error("timer trigger not a copy of the result");
  a_mode_read: assert property (s_rd(`DCC_ADDR_C0_MODE) |=> sfr_rdata[7] && !sfr_rdata[6]
    && sfr_rdata[3:2] == 2'b00) else $error("mode fixed bits wrong");
  a_read_hit: assert property (sfr_rd_en |=> sfr_hit == $past(mapped) && (sfr_hit || sfr_rdata == 8'h00))
    else $error("read hit wrong");
  a_result_bit: assert property (s_rd(`DCC_ADDR_C0_CTL) |=> sfr_rdata[6] == $past(comp0_result))
    else $error("result bit wrong");
endmodule : dcc_checker

bind dcc_top dcc_checker #(.SYNC_STAGES(SYNC_STAGES)) u_dcc_checker (
  .ref_clk(ref_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en), .sfr_rd_en(sfr_rd_en),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .comp0_raw_out(comp0_raw_out),
  .comp0_on(comp0_on), .comp0_pos_hyst(comp0_pos_hyst), .comp0_neg_hyst(comp0_neg_hyst),
  .comp0_minus_source(comp0_minus_source), .comp1_speed_sel(comp1_speed_sel),
  .comp1_plus_source(comp1_plus_source), .comp1_plus_kind(comp1_plus_kind), .comp0_result(comp0_result),
  .comp0_irq(comp0_irq), .capture_timer_trigger(capture_timer_trigger));

/* File: testbench/dual_comparator_control_regs_test.sv */
// Purpose: Self-checking bench for the comparator control block.
// Assumes: Default synchroniser depth; inputs change on the falling edge.
// Notes:   Register rows first, then edge, interrupt, priority and reset cases.
`timescale 1ns/1ps
`include "dcc_cfg.svh"

`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
  $display("BAD %0t got %h exp %h", $time, (got), (exp)); end end

module dual_comparator_control_regs_test
  import dcc_pkg::*;
;
  typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] r; logic h;} dcc_row_t;
  localparam dcc_row_t ROWS [9] = '{'{8'h9B, 8'h33, 8'h33, 1'b1}, '{8'h9A, 8'h05, 8'h05, 1'b1},
    '{8'h9D, 8'hFF, 8'hB3, 1'b1}, '{8'h9C, 8'h00, 8'h80, 1'b1}, '{8'h9F, 8'hFC, 8'hFC, 1'b1},
    '{8'h9E, 8'hDF, 8'hDF, 1'b1}, '{8'h99, 8'h55, 8'h00, 1'b0}, '{8'hA0, 8'h55, 8'h00, 1'b0},
    '{8'h9B, 8'h00, 8'h00, 1'b1}};

  logic            ref_clk;
  logic            rst = 1'b1;
  logic [7:0]      sfr_addr = 8'h00;
  logic [7:0]      sfr_wdata = 8'h00;
  logic            sfr_wr_en = 1'b0;
  logic            sfr_rd_en = 1'b0;
  logic            lvl0 = 1'b0;
  logic            lvl1 = 1'b0;
  logic [7:0]      sfr_rdata, rd;
  logic            sfr_hit, hit, seen;
  logic            comp0_raw_out, comp1_raw_out, comp0_on, comp1_on, comp0_result, comp0_irq, comp1_irq;
  logic [1:0]      comp0_speed_sel, comp1_speed_sel, comp1_pos_hyst, comp1_neg_hyst;
  logic [3:0]      comp0_plus_source, comp1_minus_source;
  logic            comp1_result;
  dcc_plus_kind_t  comp0_plus_kind, comp1_plus_kind;
  dcc_minus_kind_t comp0_minus_kind, comp1_minus_kind;
  int              miscompares = 0;
  int              tests_run = 0;

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  dcc_top i_dut (.ref_clk(ref_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
    .sfr_rd_en(sfr_rd_en), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .comp0_raw_out(comp0_raw_out), .comp1_raw_out(comp1_raw_out), .comp0_on(comp0_on),
    .comp0_pos_hyst(), .comp0_neg_hyst(), .comp0_speed_sel(comp0_speed_sel),
    .comp0_plus_source(comp0_plus_source),
    .comp0_minus_source(), .comp0_plus_kind(comp0_plus_kind), .comp0_minus_kind(comp0_minus_kind),
    .comp1_on(comp1_on), .comp1_pos_hyst(comp1_pos_hyst), .comp1_neg_hyst(comp1_neg_hyst),
    .comp1_speed_sel(comp1_speed_sel),
    .comp1_plus_source(), .comp1_minus_source(comp1_minus_source), .comp1_plus_kind(comp1_plus_kind),
    .comp1_minus_kind(comp1_minus_kind), .comp0_result(comp0_result), .comp1_result(comp1_result),
    .comp0_irq(comp0_irq), .comp1_irq(comp1_irq), .capture_timer_trigger());
  dcc_comp_model i_model0 (.on(comp0_on), .speed_sel(comp0_speed_sel), .plus_above(lvl0),
    .raw_out(comp0_raw_out));
  dcc_comp_model i_model1 (.on(comp1_on), .speed_sel(comp1_speed_sel), .plus_above(lvl1),
    .raw_out(comp1_raw_out));

  // ==========
  // Tasks
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_wr_en = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge ref_clk);
    sfr_wr_en = 1'b0;
  endtask : sfr_write

  task automatic sfr_read(input logic [7:0] a);
    @(negedge ref_clk);
    sfr_rd_en = 1'b1;
    sfr_addr = a;
    @(negedge ref_clk);
    sfr_rd_en = 1'b0;
    rd = sfr_rdata;
    hit = sfr_hit;
  endtask : sfr_read

  function automatic logic pick(input int k);
    return (k == 0) ? comp0_result : comp0_irq;
  endfunction : pick

  task automatic wait_for(input int k, input logic v);
    int n;
    n = 0;
    while (pick(k) !== v && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 20) begin
      miscompares++;
      $display("BAD %0t wait ran out", $time);
      report_and_stop();
    end
  endtask : wait_for

  // ==========
  // Sequence
  initial begin
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    foreach (ROWS[i]) begin
      sfr_write(ROWS[i].a, ROWS[i].w);
      sfr_read(ROWS[i].a);
      `CHK(rd, ROWS[i].r)
      `CHK(hit, ROWS[i].h)
    end
    `CHK(comp0_plus_kind, dcc_plus_cap_ref)
    `CHK(comp0_minus_kind, dcc_minus_ground)
    `CHK(comp1_plus_kind, dcc_plus_converter)
    `CHK(comp1_minus_kind, dcc_minus_half_batt)
    `CHK(comp0_speed_sel, 2'b11)
    `CHK(comp0_plus_source, 4'hC)
    `CHK(comp1_minus_source, 4'hD)
    `CHK({comp1_pos_hyst, comp1_neg_hyst}, 4'h5)
    // Comparator 0 rise and fall with only the rising interrupt allowed.
    sfr_write(`DCC_ADDR_C0_MODE, 8'hA0);
    sfr_write(`DCC_ADDR_C0_CTL, 8'h80);
    `CHK(comp0_on, 1'b1)
    lvl0 = 1'b1;
    wait_for(0, 1'b1);
    sfr_read(`DCC_ADDR_C0_CTL);
    `CHK(rd, 8'hE0)
    wait_for(1, 1'b1);
    `CHK(comp0_irq, 1'b1)
    lvl0 = 1'b0;
    wait_for(0, 1'b0);
    sfr_read(`DCC_ADDR_C0_CTL);
    `CHK(rd, 8'hB0)
    sfr_write(`DCC_ADDR_C0_CTL, 8'h90);
    @(negedge ref_clk);
    `CHK(comp0_irq, 1'b0)
    sfr_write(`DCC_ADDR_C0_CTL, 8'h10);
    `CHK(comp0_on, 1'b0)
    lvl0 = 1'b1;
    repeat (8) @(negedge ref_clk);
    `CHK(comp0_result, 1'b0)
    sfr_read(`DCC_ADDR_C0_CTL);
    `CHK(rd, 8'h10)
    // Comparator 1 enabled under a stream of clearing writes; the set must win once.
    lvl1 = 1'b1;
    sfr_write(`DCC_ADDR_C1_MODE, 8'hA0);
    seen = 1'b0;
    @(negedge ref_clk);
    sfr_wr_en = 1'b1;
    sfr_addr = `DCC_ADDR_C1_CTL;
    sfr_wdata = 8'h80;
    repeat (12) begin
      @(negedge ref_clk);
      if (comp1_irq === 1'b1) seen = 1'b1;
    end
    sfr_wr_en = 1'b0;
    `CHK(seen, 1'b1)
    sfr_read(`DCC_ADDR_C1_CTL);
    `CHK(rd, 8'hC0)
    `CHK(comp1_result, 1'b1)
    // Reset in mid-run returns every register to its reset value.
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    for (int i = 0; i < 6; i++) begin
      sfr_read(8'(8'h9A + i));
      `CHK(rd, i < 2 ? `DCC_RST_CTL : (i < 4 ? `DCC_RST_MODE : `DCC_RST_MUX))
    end
    `CHK(comp1_speed_sel, 2'b10)
    `CHK(comp1_on, 1'b0)
    report_and_stop();
  end
endmodule : dual_comparator_control_regs_test
